// [bench/tb_core_tick_timer_watchdog.sv]
`default_nettype none

module tb_core_tick_timer_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    import ctw_pkg::*;

    localparam int POR = 16;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, rd2;
    logic pready, pslverr, irq, sys_reset_n, err;
    logic ext_reset_n = 1, wdog_enable = 1;
    int num_errors = 0, comparisons = 0, cyc = 0, t0;

    ctw_core_timer #(.POR_CYCLES(POR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_n(ext_reset_n), .wdog_enable(wdog_enable), .irq(irq), .sys_reset_n(sys_reset_n));

    initial begin
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    // ----------------------------------------------------------------
    // Shared bus, wait and compare tasks.
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            num_errors++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic wait_lvl(ref logic s, input logic v, input int max);
        int n;
        n = 0;
        while (s !== v && n < max) begin
            @(negedge pclk);
            n++;
        end
    endtask : wait_lvl

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic t_power_on();
        repeat (POR / 2) @(posedge pclk);
        chk("por_hold", 32'h0, {31'h0, sys_reset_n});
        wait_lvl(sys_reset_n, 1'b1, 40);
        chk("por_release", 32'h1, {31'h0, sys_reset_n});
    endtask : t_power_on

    task automatic t_registers();
        apb(0, CTW_ADDR_CTL_STAT, 32'h0);
        chk("ctl_reset", 32'h03, rd);
        apb(0, CTW_ADDR_COUNT, 32'h0);
        rd2 = rd;
        chk("count_hi", 32'h0, rd & 32'hffffff00);
        repeat (37) @(posedge pclk);
        apb(0, CTW_ADDR_COUNT, 32'h0);
        chk("count_step", 32'h0a, (rd - rd2) & 32'hff);
        for (int c = 0; c < 4; c++) begin
            apb(1, CTW_ADDR_CTL_STAT, 32'h3c | c);
            apb(0, CTW_ADDR_CTL_STAT, 32'h0);
            chk("ctl_rw", 32'h30 | c, rd & 32'h3f);
        end
        apb(1, CTW_ADDR_CTL_STAT, 32'h0f);
    endtask : t_registers

    task automatic t_rollover();
        repeat (1100) @(posedge pclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(0, CTW_ADDR_CTL_STAT, 32'h0);
        chk("roll_flag", 32'h83, rd & 32'hbf);
        apb(1, CTW_ADDR_CTL_STAT, 32'h2b);
        wait_lvl(irq, 1'b0, 10);
        wait_lvl(irq, 1'b1, 1100);
        chk("roll_irq", 32'h1, {31'h0, irq});
        t0 = cyc;
        apb(0, CTW_ADDR_COUNT, 32'h0);
        chk("count_wrap", 32'h0, rd & 32'hfc);
        apb(1, CTW_ADDR_CTL_STAT, 32'h2b);
        wait_lvl(irq, 1'b0, 10);
        chk("roll_clear", 32'h0, {31'h0, irq});
        wait_lvl(irq, 1'b1, 1100);
        chk("roll_period", 32'd1024, cyc - t0);
        apb(1, CTW_ADDR_CTL_STAT, 32'h0b);
    endtask : t_rollover

    task automatic t_bus_errors();
        apb(0, 16'h0010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        apb(1, CTW_ADDR_COUNT, 32'hff);
        chk("count_wr_err", 32'h0, {31'h0, err});
    endtask : t_bus_errors

    task automatic t_periodic();
        apb(1, CTW_ADDR_SERVICE, 32'h0);
        apb(1, CTW_ADDR_CTL_STAT, 32'h1c);
        wait_lvl(irq, 1'b1, 16500);
        chk("per_irq", 32'h1, {31'h0, irq});
        t0 = cyc;
        apb(0, CTW_ADDR_CTL_STAT, 32'h0);
        chk("per_flag", 32'h50, rd & 32'h7f);
        apb(1, CTW_ADDR_CTL_STAT, 32'h14);
        apb(1, CTW_ADDR_SERVICE, 32'h1);
        apb(1, CTW_ADDR_SERVICE, 32'h0);
        wait_lvl(irq, 1'b0, 10);
        chk("per_clear", 32'h0, {31'h0, irq});
        wait_lvl(irq, 1'b1, 16500);
        chk("per_period", 32'd16384, cyc - t0);
        chk("no_timeout", 32'h1, {31'h0, sys_reset_n});
    endtask : t_periodic

    task automatic t_ext_reset();
        @(posedge pclk);
        ext_reset_n <= 0;
        repeat (4) @(posedge pclk);
        chk("ext_reset_out", 32'h0, {31'h0, sys_reset_n});
        ext_reset_n <= 1;
        wait_lvl(sys_reset_n, 1'b1, 100);
        apb(0, CTW_ADDR_CTL_STAT, 32'h0);
        chk("ctl_after_ext", 32'h03, rd);
        chk("irq_after_ext", 32'h0, {31'h0, irq});
    endtask : t_ext_reset

    // ----------------------------------------------------------------
    // Verdict and run control.
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("Comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_power_on();
        t_registers();
        t_rollover();
        t_bus_errors();
        t_periodic();
        t_ext_reset();
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        num_errors++;
        end_sim();
    end
endmodule : tb_core_tick_timer_watchdog

`default_nettype wire

// [rtl/ctw_core_timer.sv]
// Overview of operation
// - An 8-bit counter advances once every four bus clocks.
// - Software reads the 8-bit count anytime without disturbing it.
// - Rollover flag sets when the 8-bit counter wraps from ff to 00.
// - Rollover flag with rollover enable raises the interrupt request.
// - Writing one to control bit 3 clears rollover flag; reset clears it.
// - Reset clears the rollover interrupt enable.
// - Rollover happens once every 1024 bus clocks.
// - Four further stages give a clock at bus rate over 16384.
// - Three more stages, one of four taps chosen by two rate bits.
// - Watchdog divides the selected periodic tick by eight, times out on overflow.
// - Timeout lands seven to eight periodic periods after last service.
// - Service clears only the watchdog stage, chain keeps running.
// - Watchdog timeout raises an internal device reset.
// - Power-on clears the chain then counts while holding reset.
// - After the power-on hold, chain clears again; counts if pin released.
// - External reset pin during operation clears the whole chain.
// - Power-on hold is taken from the chain at 4064 bus clocks.
// - A watchdog enable input decides whether the watchdog runs.
// - Rate bits, both enables and both flags share the control register.
// - Periodic flag sets at each selected tap; with enable it requests interrupt.
// - Writing one to periodic clear bit clears flag; bit reads zero.
// - Reset selects rate code 11; codes select 2^14 up to 2^17.
// - Count register is read-only and reset to zero.
//
// Decided for this implementation: the APB slave port.

`default_nettype none

module ctw_core_timer
    import ctw_pkg::*;
#(
    parameter int POR_CYCLES = CTW_POR_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n,
    input wire logic wdog_enable,
    output logic irq,
    output logic sys_reset_n
);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic [1:0] ext_rst_sync_reg;
    logic [1:0] wdog_en_sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_rst_sync_reg <= 2'h0;
            wdog_en_sync_reg <= 2'h0;
        end else begin
            ext_rst_sync_reg <= {ext_rst_sync_reg[0], ext_reset_n};
            wdog_en_sync_reg <= {wdog_en_sync_reg[0], wdog_enable};
        end
    end

    logic ext_rst_active;
    logic wdog_on;
    assign ext_rst_active = !ext_rst_sync_reg[1];
    assign wdog_on = wdog_en_sync_reg[1];

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    logic setup_phase;
    logic access_done;
    logic hit_ctl;
    logic hit_count;
    logic hit_service;
    logic wr_ctl;
    logic wr_service;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign hit_ctl = (paddr == CTW_ADDR_CTL_STAT);
    assign hit_count = (paddr == CTW_ADDR_COUNT);
    assign hit_service = (paddr == CTW_ADDR_SERVICE);
    assign wr_ctl = access_done && pwrite && hit_ctl;
    assign wr_service = access_done && pwrite && hit_service;

    // ------------------------------------------------------------------
    // Reset sequencing.
    // ------------------------------------------------------------------
    logic por_hold_reg;
    logic wdog_fire_reg;
    logic [CTW_CHAIN_BITS-1:0] chain_reg;
    logic por_done;
    logic chain_clear;
    logic regs_clear;

    assign por_done = por_hold_reg && (chain_reg == CTW_CHAIN_BITS'(POR_CYCLES - 1));
    assign chain_clear = por_done || ext_rst_active || wdog_fire_reg;
    assign regs_clear = por_hold_reg || ext_rst_active || wdog_fire_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_hold_reg <= 1'b1;
        end else if (por_done) begin
            por_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_n <= 1'b0;
        end else begin
            sys_reset_n <= !(por_hold_reg || ext_rst_active || wdog_fire_reg);
        end
    end

    // ------------------------------------------------------------------
    // Counter chain: prescaler, 8-bit counter, four stages, three stages.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_reg <= '0;
        end else if (chain_clear) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= chain_reg + 1'b1;
        end
    end

    logic [7:0] tick_count_reg;
    assign tick_count_reg = chain_reg[CTW_PRESCALE_BITS +: CTW_COUNT_BITS];

    localparam int ROLL_BITS = CTW_PRESCALE_BITS + CTW_COUNT_BITS;
    logic roll_tick;
    assign roll_tick = !chain_clear && (&chain_reg[ROLL_BITS-1:0]);

    logic [1:0] rate_sel_reg;
    logic [CTW_CHAIN_BITS-1:0] tap_mask;
    logic rti_tick;

    // Low bits that must all be one before the selected tap rolls.
    always_comb begin
        tap_mask = '0;
        case (rate_sel_reg)
            2'h0: tap_mask = CTW_CHAIN_BITS'((1 << CTW_RTI_BASE_BITS) - 1);
            2'h1: tap_mask = CTW_CHAIN_BITS'((1 << (CTW_RTI_BASE_BITS + 1)) - 1);
            2'h2: tap_mask = CTW_CHAIN_BITS'((1 << (CTW_RTI_BASE_BITS + 2)) - 1);
            default: tap_mask = CTW_CHAIN_BITS'((1 << (CTW_RTI_BASE_BITS + 3)) - 1);
        endcase
    end

    assign rti_tick = !chain_clear && ((chain_reg & tap_mask) == tap_mask);

    // ------------------------------------------------------------------
    // Control/status register.
    // ------------------------------------------------------------------
    logic rollover_flag_reg;
    logic periodic_flag_reg;
    logic rollover_irq_en_reg;
    logic periodic_irq_en_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rollover_irq_en_reg <= 1'b0;
            periodic_irq_en_reg <= 1'b0;
            rate_sel_reg <= CTW_RATE_RESET;
        end else if (regs_clear) begin
            rollover_irq_en_reg <= 1'b0;
            periodic_irq_en_reg <= 1'b0;
            rate_sel_reg <= CTW_RATE_RESET;
        end else if (wr_ctl) begin
            rollover_irq_en_reg <= pwdata[CTW_BIT_ROLL_IE];
            periodic_irq_en_reg <= pwdata[CTW_BIT_PER_IE];
            rate_sel_reg <= {pwdata[CTW_BIT_RATE_HI], pwdata[CTW_BIT_RATE_LO]};
        end
    end

    logic roll_clr_wr;
    logic per_clr_wr;
    assign roll_clr_wr = wr_ctl && pwdata[CTW_BIT_ROLL_CLR];
    assign per_clr_wr = wr_ctl && pwdata[CTW_BIT_PER_CLR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rollover_flag_reg <= 1'b0;
        end else if (regs_clear) begin
            rollover_flag_reg <= 1'b0;
        end else if (roll_tick) begin
            rollover_flag_reg <= 1'b1;
        end else if (roll_clr_wr) begin
            rollover_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periodic_flag_reg <= 1'b0;
        end else if (regs_clear) begin
            periodic_flag_reg <= 1'b0;
        end else if (rti_tick) begin
            periodic_flag_reg <= 1'b1;
        end else if (per_clr_wr) begin
            periodic_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (rollover_flag_reg && rollover_irq_en_reg) || (periodic_flag_reg && periodic_irq_en_reg);
        end
    end

    // ------------------------------------------------------------------
    // Watchdog stage.
    // ------------------------------------------------------------------
    logic [CTW_WDOG_BITS-1:0] wdog_cnt_reg;
    logic wdog_service;
    logic wdog_overflow;

    assign wdog_service = wr_service && !pwdata[CTW_BIT_SERVICE];
    assign wdog_overflow = wdog_on && rti_tick && !wdog_service && (&wdog_cnt_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_reg <= '0;
        end else if (regs_clear || !wdog_on || wdog_service) begin
            wdog_cnt_reg <= '0;
        end else if (rti_tick) begin
            wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_fire_reg <= 1'b0;
        end else begin
            wdog_fire_reg <= wdog_overflow && !regs_clear;
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait-free access phase after every setup cycle.
    // ------------------------------------------------------------------
    logic [7:0] ctl_read;
    assign ctl_read = {rollover_flag_reg, periodic_flag_reg, rollover_irq_en_reg, periodic_irq_en_reg,
                       2'h0, rate_sel_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !(hit_ctl || hit_count || hit_service);
            if (setup_phase && !pwrite && hit_ctl) begin
                prdata <= {24'h0, ctl_read};
            end else if (setup_phase && !pwrite && hit_count) begin
                prdata <= {24'h0, tick_count_reg};
            end else if (setup_phase) begin
                prdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_service;
        wdog_service && !regs_clear;
    endsequence

    sequence seq_roll_clear;
        roll_clr_wr && !roll_tick && !regs_clear;
    endsequence

    a_roll_set: assert property (roll_tick && !regs_clear |=> rollover_flag_reg)
        else $error("rollover flag not set after wrap");
    a_roll_race: assert property (roll_tick && roll_clr_wr && !regs_clear |=> rollover_flag_reg)
        else $error("rollover event lost to a clear");
    a_roll_clear: assert property (seq_roll_clear |=> !rollover_flag_reg)
        else $error("rollover flag not cleared");
    a_roll_period: assert property (roll_tick |-> tick_count_reg == 8'hff && chain_reg[1:0] == 2'h3)
        else $error("rollover at wrong count");
    a_irq_gate: assert property (rollover_flag_reg && rollover_irq_en_reg |=> irq)
        else $error("interrupt missing");
    a_irq_quiet: assert property (!(rollover_flag_reg && rollover_irq_en_reg)
                                  && !(periodic_flag_reg && periodic_irq_en_reg) |=> !irq)
        else $error("spurious interrupt");
    a_rate_reset: assert property ($past(regs_clear) && !regs_clear |-> rate_sel_reg == CTW_RATE_RESET)
        else $error("rate select not reset to slowest");
    a_wdog_service: assert property (seq_service ##1 !chain_clear |-> wdog_cnt_reg == 0
                                     && chain_reg == $past(chain_reg) + 1'b1)
        else $error("service disturbed chain or missed stage");
    a_wdog_fire: assert property (wdog_fire_reg |-> $past(wdog_cnt_reg) == 3'h7 ##1 !sys_reset_n)
        else $error("watchdog fired at wrong stage");
    a_por_release: assert property ($fell(por_hold_reg) |-> chain_reg == 0)
        else $error("chain not cleared at power-on release");
    a_count_read: assert property (setup_phase && !pwrite && hit_count |=> prdata[7:0] == $past(tick_count_reg))
        else $error("count read mismatch");

    // ------------------------------------------------------------------
    // Periodic flag, watchdog stage, reset and bus answer checks.
    // ------------------------------------------------------------------
    // A clear that meets a tap event must lose, so the clear sequence
    // only covers cycles without a tap and outside any reset.
    sequence seq_per_clear;
        per_clr_wr && !rti_tick && !regs_clear;
    endsequence

    // A setup cycle for an address that no register answers to.
    sequence seq_bad_setup;
        setup_phase && !(hit_ctl || hit_count || hit_service);
    endsequence

    // A write to the read-only count register outside any chain clear.
    sequence seq_count_write;
        access_done && pwrite && hit_count && !chain_clear;
    endsequence

    a_per_set: assert property (rti_tick && !regs_clear |=> periodic_flag_reg)
        else $error("periodic flag not set at tap");
    a_per_race: assert property (rti_tick && per_clr_wr && !regs_clear |=> periodic_flag_reg)
        else $error("periodic event lost to a clear");
    a_per_clear: assert property (seq_per_clear |=> !periodic_flag_reg)
        else $error("periodic flag not cleared");
    a_per_irq: assert property (periodic_flag_reg && periodic_irq_en_reg |=> irq)
        else $error("periodic interrupt missing");
    a_tap_base: assert property (rti_tick |-> &chain_reg[CTW_RTI_BASE_BITS-1:0])
        else $error("periodic tap below base divider");
    a_count_wrap: assert property (roll_tick |=> tick_count_reg == 8'h00)
        else $error("count did not wrap to zero");
    a_count_ro: assert property (seq_count_write |=> chain_reg == $past(chain_reg) + 1'b1)
        else $error("count write disturbed chain");
    a_clr_read_zero: assert property (access_done && !pwrite && hit_ctl
                                      |-> prdata[CTW_BIT_ROLL_CLR] == 1'b0
                                      && prdata[CTW_BIT_PER_CLR] == 1'b0)
        else $error("clear bits did not read zero");
    a_en_reset: assert property (regs_clear |=> !rollover_irq_en_reg && !rollover_flag_reg)
        else $error("rollover enable or flag survived reset");
    a_wdog_off: assert property (!wdog_on |=> wdog_cnt_reg == '0 && !wdog_fire_reg)
        else $error("disabled watchdog advanced or fired");
    a_wdog_reset: assert property (wdog_fire_reg |=> !sys_reset_n && chain_reg == '0)
        else $error("watchdog timeout gave no device reset");
    a_ext_clear: assert property (ext_rst_active |=> !sys_reset_n && chain_reg == '0)
        else $error("external reset did not clear chain");
    a_por_hold: assert property (por_hold_reg |=> !sys_reset_n)
        else $error("device reset released during power-on hold");
    a_pready_setup: assert property (setup_phase |=> pready)
        else $error("no answer after setup cycle");
    a_pready_idle: assert property (!setup_phase |=> !pready)
        else $error("answer without setup cycle");
    a_slverr: assert property (seq_bad_setup |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");

endmodule : ctw_core_timer

`default_nettype wire

// [rtl/ctw_pkg.sv]
`default_nettype none

package ctw_pkg;

    // ------------------------------------------------------------------
    // Register map: printed offsets are word indices, byte address = 4x.
    // ------------------------------------------------------------------
    localparam logic [15:0] CTW_IDX_CTL_STAT = 16'h0008;
    localparam logic [15:0] CTW_IDX_COUNT = 16'h0009;
    localparam logic [15:0] CTW_IDX_SERVICE = 16'h1ff0;
    localparam logic [15:0] CTW_ADDR_CTL_STAT = 16'(CTW_IDX_CTL_STAT * 4);
    localparam logic [15:0] CTW_ADDR_COUNT = 16'(CTW_IDX_COUNT * 4);
    localparam logic [15:0] CTW_ADDR_SERVICE = 16'(CTW_IDX_SERVICE * 4);

    // ------------------------------------------------------------------
    // Control/status field positions.
    // ------------------------------------------------------------------
    localparam int CTW_BIT_ROLL_FLAG = 7;
    localparam int CTW_BIT_PER_FLAG = 6;
    localparam int CTW_BIT_ROLL_IE = 5;
    localparam int CTW_BIT_PER_IE = 4;
    localparam int CTW_BIT_ROLL_CLR = 3;
    localparam int CTW_BIT_PER_CLR = 2;
    localparam int CTW_BIT_RATE_HI = 1;
    localparam int CTW_BIT_RATE_LO = 0;
    localparam int CTW_BIT_SERVICE = 0;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [1:0] CTW_RATE_RESET = 2'h3;
    localparam logic [7:0] CTW_COUNT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Chain layout and timing counts in bus clock cycles.
    // ------------------------------------------------------------------
    localparam int CTW_PRESCALE_BITS = 2;
    localparam int CTW_COUNT_BITS = 8;
    localparam int CTW_RTI_BASE_BITS = 14;
    localparam int CTW_CHAIN_BITS = 17;
    localparam int CTW_POR_CYCLES = 4064;
    localparam int CTW_WDOG_BITS = 3;
    localparam int CTW_ROLL_CYCLES = 1024;

endpackage : ctw_pkg

`default_nettype wire
